//--- design/cmr_pkg.sv
// Purpose: shared constants for the converter option and calibration bank
// Assumes: one 125 MHz system clock, command codes of the management bus
// Notes:   read-only contents are factory values held as constants here
package cmr_pkg;

   // ***************************************************
   // command codes
   // ***************************************************
   localparam logic [7:0] CMD_SPECIAL_OPTS = 8'hE0;
   localparam logic [7:0] CMD_TEMP_OFFSET = 8'hE1;
   localparam logic [7:0] CMD_REMOTE_CAL = 8'hE2;
   localparam logic [7:0] CMD_REMOTE_CTRL = 8'hE3;
   localparam logic [7:0] CMD_FF_PARAMS = 8'hE6;
   localparam logic [7:0] CMD_TEMP_COEFF = 8'hE7;

   // block transfer byte counts, zero for byte and word transfers
   localparam logic [2:0] LEN_REMOTE_CAL = 3'h4;
   localparam logic [2:0] LEN_FF_PARAMS = 3'h4;
   localparam logic [2:0] LEN_TEMP_COEFF = 3'h6;
   localparam logic [7:0] NO_CMD_BYTE = 8'hFF;

   // ***************************************************
   // special option bits
   // ***************************************************
   localparam int OPT_PEC = 7;
   localparam int OPT_RATIO = 6;
   localparam int OPT_DROOP = 5;
   localparam int OPT_RAMP = 3;
   localparam int OPT_BUS_VOLT = 2;
   localparam logic [7:0] SPECIAL_WR_MASK = 8'hEC;
   localparam logic [7:0] SPECIAL_RESET = 8'h00;

   // ***************************************************
   // remote pin control bits
   // ***************************************************
   localparam int RC_AND_MODE = 4;
   localparam int RC_PIN_EN = 2;
   localparam int RC_POLARITY = 1;
   localparam int RC_QUICK_OFF = 0;
   localparam logic [7:0] REMOTE_WR_MASK = 8'h17;
   localparam logic [7:0] REMOTE_RESET = 8'h00;

   // ***************************************************
   // feed-forward fields
   // ***************************************************
   localparam int FF_EXTRA_LSB = 24;
   localparam int FF_STABLE_LSB = 16;
   localparam int FF_FAST_LSB = 8;
   localparam int FF_ENABLE = 0;
   localparam logic [31:0] FF_WR_MASK = 32'hFFFFFF01;
   localparam logic [31:0] FF_RESET = 32'h40202001;

   // ***************************************************
   // factory read-only contents
   // ***************************************************
   localparam logic [15:0] TEMP_OFFSET_VAL = 16'h0000;
   localparam logic [31:0] REMOTE_CAL_VAL = 32'h01000000;
   localparam logic [47:0] TEMP_COEFF_VAL = 48'h105A0C460F5D;
   localparam int TC_LVL1_LSB = 16;
   localparam int TC_FAC1_LSB = 24;
   localparam int TC_LVL2_LSB = 32;
   localparam int TC_FAC2_LSB = 40;

   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int REF_TICK_NS = 27000;
   localparam int REF_TICK_CYCLES = REF_TICK_NS / CLK_PERIOD_NS;
   localparam logic [11:0] REF_STEP_SLOW = 12'h001;
   localparam logic [11:0] REF_STEP_FAST = 12'h003;

endpackage

//--- design/cmr_tick_div.sv
// Purpose: one-cycle enable pulse every DIV system clocks
// Assumes: DIV of two or more
// Notes:   free-running from reset
`timescale 1ns/100ps
`default_nettype none
module cmr_tick_div #(
   parameter int DIV = 4
) (
   input wire logic clk_sys,
   input wire logic nrst,
   output logic tick
);

   logic [11:0] count_r;
   logic tick_r;
   wire lastCount = (count_r == 12'(DIV - 1));

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         count_r <= 12'h000;
         tick_r <= 1'b0;
      end else begin
         count_r <= lastCount ? 12'h000 : 12'(count_r + 12'h001);
         tick_r <= lastCount;
      end
   end

   assign tick = tick_r;

endmodule
`default_nettype wire

//--- design/cmr_mfr_config.sv
// Purpose: option, remote pin and calibration register bank with its control effects
// Assumes: bus engine presents command code, data bytes and read requests
// Notes:   block transfers carry a leading byte count, data low byte first
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - option bit 7 requires packet error checking
// - option bit 6 enables hybrid ratio regulation
// - option bit 5 picks non-linear droop
// - option bit 3 enables adaptive ramp, compensation
// - option bit 2 enables dynamic bus voltage
// - option bits 1:0 reserved, no function
// - temperature offset is read-only word
// - remote calibration: offset bytes 0-1, slope 2-3
// - control bit 4 selects OR or AND
// - control bit 2 enables the remote pin
// - control bit 1 sets pin active level
// - control bit 0: soft stop or quick off
// - big transient halves duty one period
// - stable threshold marks input ready again
// - reference steps one or three per tick
// - level one factor corrects current reading
// - level two factor corrects current reading
// - copper coefficient in low sixteen bits
module cmr_mfr_config import cmr_pkg::*; (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic cmdValid,
   input wire logic [7:0] cmdCode,
   input wire logic wrValid,
   input wire logic [7:0] wrByte,
   input wire logic rdReq,
   output logic rdValid,
   output logic [7:0] rdByte,
   output logic cmdKnown,
   output logic pecRequired,
   output logic hybridRatioEn,
   input wire logic vinBelowUvWarn,
   output logic ratioTrack,
   output logic droopNonLinear,
   output logic adaptiveRampEn,
   output logic dynBusVoltEn,
   input wire logic operationOn,
   input wire logic ctrlPinOn,
   input wire logic primaryRemotePin,
   output logic outputOn,
   output logic softStop,
   output logic quickOff,
   output logic feedForwardEn,
   input wire logic swPeriodStart,
   input wire logic [7:0] ffTransient,
   output logic dutyHalve,
   input wire logic [7:0] vinDeviation,
   output logic ffReady,
   input wire logic [11:0] refTarget,
   output logic [11:0] refDac,
   input wire logic [7:0] dieTemp,
   input wire logic [15:0] currentSense,
   output logic [15:0] outputCurrentReading
);

   // ***************************************************
   // command decode
   // ***************************************************
   function automatic logic [2:0] blockLen(input logic [7:0] cmd);
      case (cmd)
         CMD_REMOTE_CAL: blockLen = LEN_REMOTE_CAL;
         CMD_FF_PARAMS: blockLen = LEN_FF_PARAMS;
         CMD_TEMP_COEFF: blockLen = LEN_TEMP_COEFF;
         default: blockLen = 3'h0;
      endcase
   endfunction

   function automatic logic isKnown(input logic [7:0] cmd);
      isKnown = (cmd == CMD_SPECIAL_OPTS) || (cmd == CMD_TEMP_OFFSET) ||
         (cmd == CMD_REMOTE_CTRL) || (blockLen(cmd) != 3'h0);
   endfunction

   logic [7:0] cmd_r;
   logic [2:0] idx_r;
   logic known_r;
   logic [7:0] specialOpts_r;
   logic [7:0] remoteCtrl_r;
   logic [31:0] ffParams_r;
   logic rdValid_r;
   logic [7:0] rdByte_r;

   wire [2:0] curLen = blockLen(cmd_r);
   wire isBlock = (curLen != 3'h0);
   wire countByte = isBlock && (idx_r == 3'h0);
   wire [2:0] dataIdx = isBlock ? 3'(idx_r - 3'h1) : idx_r;
   wire wrOpts = wrValid && known_r && (cmd_r == CMD_SPECIAL_OPTS) && (idx_r == 3'h0);
   wire wrRemote = wrValid && known_r && (cmd_r == CMD_REMOTE_CTRL) && (idx_r == 3'h0);
   wire wrFf = wrValid && known_r && (cmd_r == CMD_FF_PARAMS) && !countByte;

   // ***************************************************
   // transfer position
   // ***************************************************
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cmd_r <= 8'h00;
         known_r <= 1'b0;
         idx_r <= 3'h0;
      end else if (cmdValid) begin
         cmd_r <= cmdCode;
         known_r <= isKnown(cmdCode);
         idx_r <= 3'h0;
      end else if ((wrValid || rdReq) && (idx_r != 3'h7)) begin
         idx_r <= 3'(idx_r + 3'h1);
      end
   end

   // ***************************************************
   // writable registers
   // ***************************************************
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         specialOpts_r <= SPECIAL_RESET;
         remoteCtrl_r <= REMOTE_RESET;
      end else begin
         if (wrOpts) begin
            specialOpts_r <= wrByte & SPECIAL_WR_MASK;
         end
         if (wrRemote) begin
            remoteCtrl_r <= wrByte & REMOTE_WR_MASK;
         end
      end
   end

   // a short block write leaves the untouched bytes as they were
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gFfByte
         always_ff @(posedge clk_sys) begin
            if (!nrst) begin
               ffParams_r[8*g +: 8] <= FF_RESET[8*g +: 8];
            end else if (wrFf && (dataIdx == 3'(g))) begin
               ffParams_r[8*g +: 8] <= wrByte & FF_WR_MASK[8*g +: 8];
            end
         end
      end
   endgenerate

   // ***************************************************
   // read path
   // ***************************************************
   // read images of the registers and the read-only constants
   wire [47:0] readImage =
      (cmd_r == CMD_SPECIAL_OPTS) ? {40'h0, specialOpts_r} :
      (cmd_r == CMD_TEMP_OFFSET) ? {32'h0, TEMP_OFFSET_VAL} :
      (cmd_r == CMD_REMOTE_CAL) ? {16'h0, REMOTE_CAL_VAL} :
      (cmd_r == CMD_REMOTE_CTRL) ? {40'h0, remoteCtrl_r} :
      (cmd_r == CMD_FF_PARAMS) ? {16'h0, ffParams_r} : TEMP_COEFF_VAL;
   wire [47:0] shiftedImage = readImage >> {dataIdx, 3'b000};
   wire [7:0] readSel = !known_r ? NO_CMD_BYTE :
      countByte ? {5'h00, curLen} : shiftedImage[7:0];

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rdValid_r <= 1'b0;
         rdByte_r <= 8'h00;
      end else begin
         rdValid_r <= rdReq;
         if (rdReq) begin
            rdByte_r <= readSel;
         end
      end
   end

   // ***************************************************
   // remote pin and output enable
   // ***************************************************
   logic outputOn_r;
   logic softStop_r;
   logic quickOff_r;
   logic ratioTrack_r;
   wire andMode = remoteCtrl_r[RC_AND_MODE];
   wire pinAsserted = remoteCtrl_r[RC_POLARITY] ? primaryRemotePin : !primaryRemotePin;
   // disabled pin is neutral in either mode
   wire pinTerm = remoteCtrl_r[RC_PIN_EN] ? pinAsserted : andMode;
   // combine with operation and control pin
   wire onNxt = andMode ? (operationOn && ctrlPinOn && pinTerm) :
      (operationOn || ctrlPinOn || pinTerm);
   wire turnOff = outputOn_r && !onNxt;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         outputOn_r <= 1'b0;
         softStop_r <= 1'b0;
         quickOff_r <= 1'b0;
         ratioTrack_r <= 1'b0;
      end else begin
         outputOn_r <= onNxt;
         softStop_r <= turnOff && !remoteCtrl_r[RC_QUICK_OFF];
         quickOff_r <= turnOff && remoteCtrl_r[RC_QUICK_OFF];
         ratioTrack_r <= specialOpts_r[OPT_RATIO] && vinBelowUvWarn;
      end
   end

   // ***************************************************
   // feed-forward and reference stepping
   // ***************************************************
   logic dutyHalve_r;
   logic ffReady_r;
   logic [11:0] refDac_r;
   logic refTick;
   wire [11:0] refDiff = (refTarget > refDac_r) ? 12'(refTarget - refDac_r) :
      12'(refDac_r - refTarget);
   wire [11:0] stepWant = (refDiff < {4'h0, ffParams_r[FF_FAST_LSB +: 8]}) ?
      REF_STEP_SLOW : REF_STEP_FAST;
   wire [11:0] stepSize = (refDiff < stepWant) ? refDiff : stepWant;

   cmr_tick_div #(.DIV(REF_TICK_CYCLES)) uTick (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .tick(refTick)
   );

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         dutyHalve_r <= 1'b0;
         ffReady_r <= 1'b0;
         refDac_r <= 12'h000;
      end else begin
         // held for a whole switching period
         if (swPeriodStart) begin
            dutyHalve_r <= ffParams_r[FF_ENABLE] &&
               (ffTransient > ffParams_r[FF_EXTRA_LSB +: 8]);
         end
         ffReady_r <= (vinDeviation <= ffParams_r[FF_STABLE_LSB +: 8]);
         if (refTick) begin
            refDac_r <= (refTarget > refDac_r) ? 12'(refDac_r + stepSize) :
               12'(refDac_r - stepSize);
         end
      end
   end

   // ***************************************************
   // temperature compensated current reading
   // ***************************************************
   logic [15:0] reading_r;
   wire [7:0] level1 = TEMP_COEFF_VAL[TC_LVL1_LSB +: 8];
   wire [7:0] level2 = TEMP_COEFF_VAL[TC_LVL2_LSB +: 8];
   wire [7:0] compFactor = (dieTemp > level2) ? TEMP_COEFF_VAL[TC_FAC2_LSB +: 8] :
      (dieTemp > level1) ? TEMP_COEFF_VAL[TC_FAC1_LSB +: 8] : 8'h00;
   wire [23:0] compProduct = currentSense * compFactor;
   wire [16:0] compSum = {1'b0, currentSense} + {1'b0, compProduct[23:8]};

   // saturate rather than wrap so a hot overload never reads small
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         reading_r <= 16'h0000;
      end else begin
         reading_r <= compSum[16] ? 16'hFFFF : compSum[15:0];
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign rdValid = rdValid_r;
   assign rdByte = rdByte_r;
   assign cmdKnown = known_r;
   assign pecRequired = specialOpts_r[OPT_PEC];
   assign hybridRatioEn = specialOpts_r[OPT_RATIO];
   assign droopNonLinear = specialOpts_r[OPT_DROOP];
   assign adaptiveRampEn = specialOpts_r[OPT_RAMP];
   assign dynBusVoltEn = specialOpts_r[OPT_BUS_VOLT];
   assign ratioTrack = ratioTrack_r;
   assign outputOn = outputOn_r;
   assign softStop = softStop_r;
   assign quickOff = quickOff_r;
   assign feedForwardEn = ffParams_r[FF_ENABLE];
   assign dutyHalve = dutyHalve_r;
   assign ffReady = ffReady_r;
   assign refDac = refDac_r;
   assign outputCurrentReading = reading_r;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence sOptWrite;
      wrValid && !cmdValid && known_r && (cmd_r == CMD_SPECIAL_OPTS) && (idx_r == 3'h0);
   endsequence

   sequence sReadAt(logic [7:0] cmd, logic [2:0] pos);
      rdReq && !cmdValid && (cmd_r == cmd) && (idx_r == pos);
   endsequence

   chk_pec_follow: assert property (sOptWrite |=> pecRequired == $past(wrByte[7]))
      else $error("pec option does not follow write");
   chk_opt_bits: assert property (sOptWrite |=>
      {droopNonLinear, adaptiveRampEn, dynBusVoltEn} == $past({wrByte[5], wrByte[3:2]}))
      else $error("option bits do not follow write");
   chk_opt_reserved: assert property (sOptWrite |=>
      (specialOpts_r[1:0] == 2'h0) && !specialOpts_r[4])
      else $error("reserved option bit holds a one");
   chk_ratio_track: assert property (hybridRatioEn && vinBelowUvWarn && !wrOpts
      |=> ratioTrack) else $error("ratio tracking missing");
   chk_temp_read: assert property (sReadAt(CMD_TEMP_OFFSET, 3'h0) |=>
      rdValid && rdByte == TEMP_OFFSET_VAL[7:0]) else $error("temperature offset misread");
   chk_cal_slope: assert property (sReadAt(CMD_REMOTE_CAL, 3'h3) |=>
      rdValid && rdByte == REMOTE_CAL_VAL[23:16]) else $error("calibration byte misread");
   chk_coeff_low: assert property (sReadAt(CMD_TEMP_COEFF, 3'h1) |=>
      rdValid && rdByte == TEMP_COEFF_VAL[7:0]) else $error("copper coefficient misread");
   chk_remote_and: assert property (andMode && remoteCtrl_r[RC_PIN_EN] &&
      remoteCtrl_r[RC_POLARITY] && !primaryRemotePin |=> !outputOn)
      else $error("pin ignored in and mode");
   chk_remote_off: assert property (!andMode && !remoteCtrl_r[RC_PIN_EN] &&
      !operationOn && !ctrlPinOn |=> !outputOn) else $error("disabled pin turned output on");
   chk_stop_kind: assert property ($fell(outputOn) |->
      (quickOff == $past(remoteCtrl_r[RC_QUICK_OFF])) && (softStop != quickOff))
      else $error("wrong disable mode");
   chk_duty_cut: assert property (swPeriodStart && feedForwardEn &&
      (ffTransient > ffParams_r[31:24]) |=> dutyHalve) else $error("duty not halved");
   chk_ff_ready: assert property ((vinDeviation > ffParams_r[23:16]) |=> !ffReady)
      else $error("unstable input marked ready");
   chk_ref_step: assert property (refTick && (refDiff >= 12'h003)
      |=> ($past(refDiff) < {4'h0, $past(ffParams_r[15:8])} ? 12'h001 : 12'h003) ==
      (refDac > $past(refDac) ? 12'(refDac - $past(refDac)) : 12'($past(refDac) - refDac)))
      else $error("reference step wrong");
   chk_cool_read: assert property (dieTemp <= level1 && dieTemp <= level2
      |=> outputCurrentReading == $past(currentSense)) else $error("cool reading altered");

endmodule
`default_nettype wire

//--- bench/cmr_host_model.sv
// Purpose: management host model driving the command byte port
// Assumes: requests launched at the falling edge, read answer one cycle later
// Notes:   idle data lines show the inverse of the last value, never a stale copy
`timescale 1ns/100ps
`default_nettype none
module cmr_host_model (
   input wire logic clk_sys,
   input wire logic rdValid,
   input wire logic [7:0] rdByte,
   output logic cmdValid,
   output logic [7:0] cmdCode,
   output logic wrValid,
   output logic [7:0] wrByte,
   output logic rdReq
);
   // extra idle cycles before each request, so the host can be slow as well as prompt
   int pace = 0;
   initial begin
      cmdValid = 1'b0;
      cmdCode = 8'h00;
      wrValid = 1'b0;
      wrByte = 8'h00;
      rdReq = 1'b0;
   end
   task automatic send_cmd(input logic [7:0] c);
      repeat (pace + 1) @(negedge clk_sys);
      cmdValid = 1'b1;
      cmdCode = c;
      @(negedge clk_sys);
      cmdValid = 1'b0;
      cmdCode = ~c;
   endtask
   // only bytes handed in are sent
   task automatic put_byte(input logic [7:0] d);
      repeat (pace + 1) @(negedge clk_sys);
      wrValid = 1'b1;
      wrByte = d;
      @(negedge clk_sys);
      wrValid = 1'b0;
      wrByte = ~d;
   endtask
   task automatic get_byte(output logic [7:0] b);
      repeat (pace + 1) @(negedge clk_sys);
      rdReq = 1'b1;
      @(negedge clk_sys);
      rdReq = 1'b0;
      b = (rdValid === 1'b1) ? rdByte : 8'hXX;
   endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Purpose: self-checking bench for the option and calibration bank
// Assumes: inputs change at the falling clock edge
// Notes:   reference stepping needs several 27 us ticks, the longest part
`timescale 1ns/100ps
`default_nettype none
module tb import cmr_pkg::*; ;
   typedef struct {
      logic [7:0] cmd; logic blk; int n; logic [47:0] wd; logic [47:0] ex; logic known;
   } cmr_row_t;
   logic clk_sys, nrst, cmdValid, wrValid, rdReq, rdValid, cmdKnown, pecRequired;
   logic hybridRatioEn, vinBelowUvWarn, ratioTrack, droopNonLinear, adaptiveRampEn;
   logic dynBusVoltEn, operationOn, ctrlPinOn, primaryRemotePin, outputOn, softStop;
   logic quickOff, feedForwardEn, swPeriodStart, dutyHalve, ffReady;
   logic [7:0] cmdCode, wrByte, rdByte, ffTransient, vinDeviation, dieTemp;
   logic [11:0] refTarget, refDac;
   logic [15:0] currentSense, outputCurrentReading;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   cmr_row_t rows [8] = '{
      '{8'hE0, 1'b0, 2, 48'hFFFF, 48'h00EC, 1'b1},
      '{8'hE0, 1'b0, 1, 48'h00, 48'h00, 1'b1},
      '{8'hE3, 1'b0, 1, 48'hFF, 48'h17, 1'b1},
      '{8'hE6, 1'b1, 4, 48'h12345678, 48'h12345600, 1'b1},
      '{8'hE1, 1'b0, 2, 48'hFFFF, {32'h0, TEMP_OFFSET_VAL}, 1'b1},
      '{8'hE2, 1'b1, 4, 48'hFFFFFFFF, {16'h0, REMOTE_CAL_VAL}, 1'b1},
      '{8'hE7, 1'b1, 6, 48'hFFFFFFFFFFFF, TEMP_COEFF_VAL, 1'b1},
      '{8'hE4, 1'b0, 1, 48'h00, 48'hFF, 1'b0}};
   logic [7:0] cfgs [6] = '{8'h00, 8'h04, 8'h06, 8'h10, 8'h14, 8'h16};
   logic [7:0] temps [5] = '{8'h46, 8'h47, 8'h5A, 8'h5B, 8'h5B};
   logic [15:0] senses [5] = '{16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'hFFF0};

   cmr_host_model host (.clk_sys(clk_sys), .rdValid(rdValid), .rdByte(rdByte),
      .cmdValid(cmdValid), .cmdCode(cmdCode), .wrValid(wrValid), .wrByte(wrByte),
      .rdReq(rdReq));
   cmr_mfr_config dut (.clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid),
      .cmdCode(cmdCode), .wrValid(wrValid), .wrByte(wrByte), .rdReq(rdReq),
      .rdValid(rdValid), .rdByte(rdByte), .cmdKnown(cmdKnown), .pecRequired(pecRequired),
      .hybridRatioEn(hybridRatioEn), .vinBelowUvWarn(vinBelowUvWarn), .ratioTrack(ratioTrack),
      .droopNonLinear(droopNonLinear), .adaptiveRampEn(adaptiveRampEn),
      .dynBusVoltEn(dynBusVoltEn), .operationOn(operationOn), .ctrlPinOn(ctrlPinOn),
      .primaryRemotePin(primaryRemotePin), .outputOn(outputOn), .softStop(softStop),
      .quickOff(quickOff), .feedForwardEn(feedForwardEn), .swPeriodStart(swPeriodStart),
      .ffTransient(ffTransient), .dutyHalve(dutyHalve), .vinDeviation(vinDeviation),
      .ffReady(ffReady), .refTarget(refTarget), .refDac(refDac), .dieTemp(dieTemp),
      .currentSense(currentSense), .outputCurrentReading(outputCurrentReading));

   always #4 clk_sys = ~clk_sys;

   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [47:0] seen, input logic [47:0] ex);
      n_compared++;
      if (seen !== ex) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, ex);
      end
   endtask
   task automatic wr_reg(input logic [7:0] c, input logic blk, input int n,
         input logic [47:0] d);
      host.send_cmd(c);
      if (blk) host.put_byte(n[7:0]);
      for (int i = 0; i < n; i++) host.put_byte(d[8*i +: 8]);
   endtask
   task automatic rd_reg(input logic [7:0] c, input logic blk, input int n,
         output logic [47:0] v);
      logic [7:0] b;
      host.send_cmd(c);
      v = '0;
      if (blk) begin
         host.get_byte(b);
         check(b, n[7:0]);
      end
      for (int i = 0; i < n; i++) begin
         host.get_byte(b);
         v[8*i +: 8] = b;
      end
   endtask
   task automatic wait_ref(output int cyc);
      logic [11:0] old;
      old = refDac;
      cyc = 0;
      while (refDac === old && cyc < 4000) begin
         @(negedge clk_sys);
         cyc++;
      end
   endtask
   function automatic logic rc_exp(input logic [7:0] cfg, input logic [2:0] k);
      logic pinTerm;
      pinTerm = cfg[2] ? (cfg[1] ? k[0] : ~k[0]) : cfg[4];
      return cfg[4] ? (&k[2:1] & pinTerm) : (|k[2:1] | pinTerm);
   endfunction
   function automatic logic [15:0] cur_exp(input logic [7:0] t, input logic [15:0] s);
      int f;
      int r;
      f = (t > TEMP_COEFF_VAL[39:32]) ? TEMP_COEFF_VAL[47:40] :
         (t > TEMP_COEFF_VAL[23:16]) ? TEMP_COEFF_VAL[31:24] : 0;
      r = s + ((s * f) >> 8);
      return (r > 65535) ? 16'hFFFF : r[15:0];
   endfunction

   // ***************************************************
   // run limit, well above the four reference ticks
   // ***************************************************
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         finish_test();
      end
   end

   initial begin
      logic [47:0] v;
      logic [7:0] o;
      int c;
      int sc;
      int qc;
      clk_sys = 1'b0;
      nrst = 1'b0;
      {vinBelowUvWarn, operationOn, ctrlPinOn, primaryRemotePin, swPeriodStart} = 5'h00;
      {ffTransient, vinDeviation, dieTemp} = 24'h000000;
      refTarget = 12'h000;
      currentSense = 16'h0000;
      repeat (5) @(negedge clk_sys);
      nrst = 1'b1;
      rd_reg(8'hE0, 1'b0, 1, v);
      check(v, SPECIAL_RESET);
      rd_reg(8'hE6, 1'b1, 4, v);
      check(v, FF_RESET);
      check(feedForwardEn, FF_RESET[FF_ENABLE]);
      $display("test reset done");
      host.pace = 1;
      foreach (rows[i]) begin
         wr_reg(rows[i].cmd, rows[i].blk, rows[i].n, rows[i].wd);
         rd_reg(rows[i].cmd, rows[i].blk, rows[i].n, v);
         check(v, rows[i].ex);
         check(cmdKnown, rows[i].known);
      end
      host.pace = 0;
      $display("test table done");
      vinBelowUvWarn = 1'b1;
      for (int i = 0; i < 8; i++) begin
         o = 8'h80 >> i;
         wr_reg(8'hE0, 1'b0, 1, o);
         repeat (2) @(negedge clk_sys);
         check({pecRequired, hybridRatioEn, droopNonLinear, ratioTrack, adaptiveRampEn,
            dynBusVoltEn, 2'h0}, (o & 8'hEC) | {3'h0, o[6], 4'h0});
      end
      $display("test options done");
      foreach (cfgs[j]) begin
         wr_reg(8'hE3, 1'b0, 1, cfgs[j]);
         for (int k = 0; k < 8; k++) begin
            {operationOn, ctrlPinOn, primaryRemotePin} = k[2:0];
            repeat (2) @(negedge clk_sys);
            check(outputOn, rc_exp(cfgs[j], k[2:0]));
         end
      end
      for (int m = 0; m < 2; m++) begin
         wr_reg(8'hE3, 1'b0, 1, m);
         {operationOn, ctrlPinOn, primaryRemotePin} = 3'b100;
         repeat (3) @(negedge clk_sys);
         operationOn = 1'b0;
         sc = 0;
         qc = 0;
         repeat (4) begin
            @(negedge clk_sys);
            sc += (softStop === 1'b1);
            qc += (quickOff === 1'b1);
         end
         check({sc[7:0], qc[7:0]}, (m == 0) ? 16'h0100 : 16'h0001);
      end
      $display("test remote done");
      wr_reg(8'hE6, 1'b1, 4, 48'h40201001);
      {ffTransient, vinDeviation} = 16'h4120;
      repeat (2) @(negedge clk_sys);
      check({dutyHalve, ffReady}, 2'h1);
      for (int p = 0; p < 2; p++) begin
         swPeriodStart = 1'b1;
         @(negedge clk_sys);
         swPeriodStart = 1'b0;
         {ffTransient, vinDeviation} = 16'h4021;
         @(negedge clk_sys);
         check({dutyHalve, ffReady}, (p == 0) ? 2'h2 : 2'h0);
      end
      $display("test feed forward done");
      refTarget = 12'h100;
      wait_ref(c);
      check(refDac, 12'h003);
      wait_ref(c);
      check({c, refDac}, {REF_TICK_CYCLES, 12'h006});
      refTarget = 12'h00C;
      wait_ref(c);
      check(refDac, 12'h007);
      refTarget = 12'h005;
      wait_ref(c);
      check(refDac, 12'h006);
      wr_reg(8'hE6, 1'b1, 4, FF_RESET);
      $display("test reference done");
      foreach (temps[i]) begin
         dieTemp = temps[i];
         currentSense = senses[i];
         repeat (2) @(negedge clk_sys);
         check(outputCurrentReading, cur_exp(temps[i], senses[i]));
      end
      $display("test current done");
      nrst = 1'b0;
      repeat (5) @(negedge clk_sys);
      nrst = 1'b1;
      check({outputOn, refDac}, 13'h0000);
      rd_reg(8'hE0, 1'b0, 1, v);
      check(v, SPECIAL_RESET);
      $display("test second reset done");
      finish_test();
   end
endmodule
`default_nettype wire
